// ---- rgc_top.sv ----
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "rgc_regs.svh"

module rgc_top
  import rgc_pkg::*;
#(
  parameter bit SUPPORT_AFL = 1'b1,
  parameter bit REQUIRE_WBF = 1'b1,
  parameter bit SUPPORT_QI = 1'b1,
  parameter bit SUPPORT_IR = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic adv_fault_log_enable,
  output logic write_buffer_flush_req,
  input wire logic write_buffer_flush_done,
  output logic queued_inval_enable,
  output logic irq_remap_enable,
  output logic irq_drain_req,
  input wire logic irq_queue_empty,
  input wire logic irq_txn_idle,
  output logic [31:0] irq_table_ptr
);

  // ----------------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------------
  // Shared by the write and read paths so both agree on the map
  function automatic logic addr_mapped(input rgc_addr_t a);
    addr_mapped = (a == `RGC_GCMD_OFF) || (a == `RGC_GSTS_OFF) ||
                  (a == `RGC_IRTA_OFF) || (a == `RGC_IRTP_OFF) ||
                  (a == `RGC_FEAT_OFF);
  endfunction : addr_mapped

  // ----------------------------------------------------------------------
  // Bus slave and handshake sequencers
  // ----------------------------------------------------------------------
  rgc_reg_if rb ();
  rgc_seq_if write_buffer_flush ();
  rgc_seq_if ird ();

  // Protection attributes carry no meaning for this bank
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot};

  rgc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb)
  );

  rgc_seq u_wbf_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .sq(write_buffer_flush)
  );

  rgc_seq u_irq_drain_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .sq(ird)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic afl_status_ff;
  logic wbf_status_ff;
  logic qi_status_ff;
  logic ir_status_ff;
  logic ir_target_ff;
  logic ptr_status_ff;
  logic ptr_loaded_ff;
  rgc_data_t irq_table_address_ff;
  rgc_data_t irq_table_ptr_ff;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Command bits live in the top byte, so that lane must be enabled
  wire gcmd_wr = rb.wr_en && (rb.wr_addr == `RGC_GCMD_OFF) && rb.wr_strb[`RGC_CMD_LANE];
  wire irta_wr = rb.wr_en && (rb.wr_addr == `RGC_IRTA_OFF);
  wire cmd_afl = rb.wr_data[`RGC_AFL_BIT];
  wire cmd_wbf = rb.wr_data[`RGC_WBF_BIT];
  wire cmd_qie = rb.wr_data[`RGC_QIE_BIT];
  wire cmd_ire = rb.wr_data[`RGC_IRE_BIT];
  wire cmd_set_irq_table_ptr = rb.wr_data[`RGC_SET_IRQ_TABLE_PTR_BIT];

  wire afl_wr = gcmd_wr && SUPPORT_AFL;
  wire qi_wr = gcmd_wr && SUPPORT_QI;
  wire wbf_start = gcmd_wr && REQUIRE_WBF && cmd_wbf && !write_buffer_flush.busy;
  wire set_irq_table_ptr_wr = gcmd_wr && SUPPORT_IR && cmd_set_irq_table_ptr;
  // A drain already running keeps its target; a same-value write is a no-op
  wire ire_start = gcmd_wr && SUPPORT_IR && (cmd_ire != ir_status_ff) && !ird.busy;

  // Sequencer hookup
  assign write_buffer_flush.start = wbf_start;
  assign write_buffer_flush.done_in = write_buffer_flush_done;
  assign ird.start = ire_start;
  assign ird.done_in = irq_queue_empty && irq_txn_idle;

  // ----------------------------------------------------------------------
  // Fault logging and queued invalidation
  // ----------------------------------------------------------------------
  // Enable and status share one flop
  wire nxt_afl_status = afl_wr ? cmd_afl : afl_status_ff;
  wire nxt_qi_status = qi_wr ? cmd_qie : qi_status_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afl_status_ff <= `RGC_FLAG_RST;
      qi_status_ff <= `RGC_FLAG_RST;
    end else begin
      afl_status_ff <= nxt_afl_status;
      qi_status_ff <= nxt_qi_status;
    end
  end

  // ----------------------------------------------------------------------
  // Write buffer flush
  // ----------------------------------------------------------------------
  // Status high while flushing
  wire nxt_wbf_status = wbf_start ? 1'b1 : (write_buffer_flush.complete ? 1'b0 : wbf_status_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) wbf_status_ff <= `RGC_FLAG_RST;
    else wbf_status_ff <= nxt_wbf_status;
  end

  // ----------------------------------------------------------------------
  // Interrupt remapping enable
  // ----------------------------------------------------------------------
  // Switch on drain completion
  wire nxt_ir_status = ird.complete ? ir_target_ff : ir_status_ff;
  wire nxt_ir_target = ire_start ? cmd_ire : ir_target_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_status_ff <= `RGC_FLAG_RST;
      ir_target_ff <= `RGC_FLAG_RST;
    end else begin
      ir_status_ff <= nxt_ir_status;
      ir_target_ff <= nxt_ir_target;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt remap table pointer
  // ----------------------------------------------------------------------
  // Address register takes byte lanes one by one
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irta_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) irq_table_address_ff[gi*8 +: 8] <= `RGC_BYTE_RST;
        else if (irta_wr && rb.wr_strb[gi])
          irq_table_address_ff[gi*8 +: 8] <= rb.wr_data[gi*8 +: 8];
      end
    end
  endgenerate

  // Load pointer, clear status, set one cycle later
  wire nxt_ptr_status = set_irq_table_ptr_wr ? 1'b0 : 1'b1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_table_ptr_ff <= `RGC_PTR_RST;
      ptr_status_ff <= `RGC_FLAG_RST;
    end else begin
      if (set_irq_table_ptr_wr) irq_table_ptr_ff <= irq_table_address_ff;
      if (set_irq_table_ptr_wr || ptr_status_ff == 1'b0 && ptr_loaded_ff) ptr_status_ff <= nxt_ptr_status;
    end
  end

  // Remembers that a load has happened, so status only rises after one
  always_ff @(posedge aclk) begin
    if (!aresetn) ptr_loaded_ff <= `RGC_FLAG_RST;
    else if (set_irq_table_ptr_wr) ptr_loaded_ff <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [31:0] gsts_word = (32'(afl_status_ff) << `RGC_AFL_BIT) |
                          (32'(wbf_status_ff) << `RGC_WBF_BIT) |
                          (32'(qi_status_ff) << `RGC_QIE_BIT) |
                          (32'(ir_status_ff) << `RGC_IRE_BIT) |
                          (32'(ptr_status_ff) << `RGC_SET_IRQ_TABLE_PTR_BIT);
  wire [31:0] feat_word = {28'h0000000, SUPPORT_IR, SUPPORT_QI, REQUIRE_WBF, SUPPORT_AFL};
  assign rb.rd_data = (rb.rd_addr == `RGC_GSTS_OFF) ? gsts_word :
                      (rb.rd_addr == `RGC_IRTA_OFF) ? irq_table_address_ff :
                      (rb.rd_addr == `RGC_IRTP_OFF) ? irq_table_ptr_ff :
                      (rb.rd_addr == `RGC_FEAT_OFF) ? feat_word : `RGC_DATA_RST;
  assign rb.rd_ok = addr_mapped(rb.rd_addr);
  // Writes to read-only words are accepted and dropped
  assign rb.wr_ok = addr_mapped(rb.wr_addr);

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Flush request held until done
  assign write_buffer_flush_req = write_buffer_flush.req;
  assign irq_drain_req = ird.req;
  assign adv_fault_log_enable = afl_status_ff;
  assign queued_inval_enable = qi_status_ff;
  assign irq_remap_enable = ir_status_ff;
  assign irq_table_ptr = irq_table_ptr_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_AFL_UNSUPPORTED: assert property (
    !SUPPORT_AFL |-> !adv_fault_log_enable)
    else $error("fault log enabled without support");
  AST_AFL_OFF: assert property (
    afl_wr && !cmd_afl |=> !adv_fault_log_enable)
    else $error("fault log not disabled");
  AST_AFL_ON: assert property (
    afl_wr && cmd_afl |=> adv_fault_log_enable && gsts_word[`RGC_AFL_BIT])
    else $error("fault log not enabled");
  AST_WBF_START: assert property (
    wbf_start |=> write_buffer_flush_req && wbf_status_ff)
    else $error("flush not started");
  AST_WBF_END: assert property (
    $fell(wbf_status_ff) |-> $past(write_buffer_flush_done) && !write_buffer_flush_req)
    else $error("flush status cleared early");
  AST_ZERO_NOP: assert property (
    gcmd_wr && !cmd_wbf && !cmd_set_irq_table_ptr |=> $stable(irq_table_ptr) && !$rose(write_buffer_flush_req))
    else $error("zero command had effect");
  AST_GCMD_READ: assert property (
    rb.rd_addr == `RGC_GCMD_OFF |-> rb.rd_data == `RGC_DATA_RST)
    else $error("command word read not zero");
  AST_QI_APPLY: assert property (
    qi_wr |=> queued_inval_enable == $past(cmd_qie))
    else $error("queued invalidation not applied");
  AST_IR_REQ: assert property (
    ire_start |=> irq_drain_req && $stable(irq_remap_enable))
    else $error("remap switched before drain");
  AST_IR_BOUNDARY: assert property (
    $changed(irq_remap_enable) |-> $past(irq_txn_idle) && $past(irq_drain_req))
    else $error("remap switched mid transaction");
  AST_IR_DRAINED: assert property (
    $changed(irq_remap_enable) |-> $past(irq_queue_empty))
    else $error("remap switched with queued interrupts");
  AST_PTR_LOAD: assert property (
    set_irq_table_ptr_wr |=> irq_table_ptr == $past(irq_table_address_ff))
    else $error("table pointer not loaded");
  AST_PTR_STATUS: assert property (
    set_irq_table_ptr_wr |=> !ptr_status_ff ##1 ptr_status_ff)
    else $error("table pointer status sequence wrong");

endmodule : rgc_top

`default_nettype wire

// ---- rgc_regs.svh ----
`ifndef RGC_REGS_SVH
`define RGC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RGC_GCMD_OFF 12'h018
`define RGC_GSTS_OFF 12'h01c
`define RGC_IRTA_OFF 12'h020
`define RGC_IRTP_OFF 12'h024
`define RGC_FEAT_OFF 12'h028

// ----------------------------------------------------------------------
// Command and status bit positions (same position in both words)
// ----------------------------------------------------------------------
`define RGC_AFL_BIT 28
`define RGC_WBF_BIT 27
`define RGC_QIE_BIT 26
`define RGC_IRE_BIT 25
`define RGC_SET_IRQ_TABLE_PTR_BIT 24
`define RGC_CMD_LANE 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RGC_FLAG_RST 1'b0
`define RGC_PTR_RST 32'h0000_0000
`define RGC_BYTE_RST 8'h00
`define RGC_DATA_RST 32'h0000_0000
`define RGC_ADDR_RST 12'h000
`define RGC_STRB_RST 4'h0

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define RGC_RESP_OKAY 2'b00
`define RGC_RESP_DECERR 2'b11

`endif

// ---- rgc_pkg.sv ----
`default_nettype none

package rgc_pkg;
  typedef logic [11:0] rgc_addr_t;
  typedef logic [31:0] rgc_data_t;
  // Drain / flush handshake sequencer
  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } rgc_seq_state_t;
endpackage : rgc_pkg

`default_nettype wire

// ---- rgc_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Register access between bus slave and register bank
// ----------------------------------------------------------------------
interface rgc_reg_if;
  logic wr_en;
  rgc_pkg::rgc_addr_t wr_addr;
  rgc_pkg::rgc_data_t wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  rgc_pkg::rgc_addr_t rd_addr;
  rgc_pkg::rgc_data_t rd_data;
  logic rd_ok;
  modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : rgc_reg_if

// ----------------------------------------------------------------------
// Request / done handshake toward the root complex
// ----------------------------------------------------------------------
interface rgc_seq_if;
  logic start;
  logic done_in;
  logic req;
  logic busy;
  logic complete;
  modport ctl (output start, done_in, input req, busy, complete);
  modport seq (input start, done_in, output req, busy, complete);
endinterface : rgc_seq_if

`default_nettype wire

// ---- rgc_seq.sv ----
`timescale 1ns/1ps
`default_nettype none

module rgc_seq
  import rgc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  rgc_seq_if.seq sq
);

  rgc_seq_state_t state_ff;
  rgc_seq_state_t nxt_state;

  // Request stands until the far side reports done
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SEQ_IDLE: if (sq.start) nxt_state = SEQ_WAIT;
      SEQ_WAIT: if (sq.done_in) nxt_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state_ff <= SEQ_IDLE;
    else state_ff <= nxt_state;
  end

  // Completion is the done cycle itself, so the caller switches at that edge
  assign sq.req = (state_ff == SEQ_WAIT);
  assign sq.busy = (state_ff == SEQ_WAIT);
  assign sq.complete = (state_ff == SEQ_WAIT) && sq.done_in;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_REQ_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    sq.req && !sq.done_in |=> sq.req)
    else $error("request dropped before done");
  AST_REQ_ENDS: assert property (@(posedge aclk) disable iff (!aresetn)
    sq.complete |=> !sq.req)
    else $error("request stayed after completion");

endmodule : rgc_seq

`default_nettype wire

// ---- rgc_axil.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "rgc_regs.svh"

module rgc_axil
  import rgc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  rgc_reg_if.slv rb
);

  logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
  rgc_addr_t awaddr_ff;
  rgc_data_t wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // Address and data are held apart so either may come first
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  // Register write strobe once both halves are held
  assign rb.wr_en = aw_ff && w_ff;
  assign rb.wr_addr = awaddr_ff;
  assign rb.wr_data = wdata_ff;
  assign rb.wr_strb = wstrb_ff;
  assign rb.rd_addr = s_axi_araddr;

  // Write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= `RGC_FLAG_RST;
      w_ff <= `RGC_FLAG_RST;
      awaddr_ff <= `RGC_ADDR_RST;
      wdata_ff <= `RGC_DATA_RST;
      wstrb_ff <= `RGC_STRB_RST;
      bvalid_ff <= `RGC_FLAG_RST;
      bresp_ff <= `RGC_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (rb.wr_en) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= rb.wr_ok ? `RGC_RESP_OKAY : `RGC_RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel, data registered on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= `RGC_FLAG_RST;
      rdata_ff <= `RGC_DATA_RST;
      rresp_ff <= `RGC_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rb.rd_ok ? rb.rd_data : `RGC_DATA_RST;
      rresp_ff <= rb.rd_ok ? `RGC_RESP_OKAY : `RGC_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule : rgc_axil

`default_nettype wire

// ---- remap_global_command_ops_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "rgc_regs.svh"

// Compare, count, report at once
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module remap_global_command_ops_tb_top
  import rgc_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct packed {logic [31:0] d; logic [3:0] s; logic afl; logic qi;} rgc_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, irq_table_ptr, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic adv_fault_log_enable, write_buffer_flush_req, write_buffer_flush_done;
  logic queued_inval_enable, irq_remap_enable, irq_drain_req, irq_queue_empty, irq_txn_idle;
  int miscompares, check_count;
  rgc_row_t rows [5];

  rgc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .adv_fault_log_enable, .write_buffer_flush_req, .write_buffer_flush_done,
    .queued_inval_enable, .irq_remap_enable, .irq_drain_req, .irq_queue_empty,
    .irq_txn_idle, .irq_table_ptr);

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  // Both halves offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    if (n >= 60) miscompares++;
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    if (n >= 60) miscompares++;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic chk_sts(input logic [31:0] e);
    axr(`RGC_GSTS_OFF);
    `CHK("status", e, rd)
  endtask : chk_sts

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Hang guard, far beyond the under two hundred cycles needed
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    {write_buffer_flush_done, irq_txn_idle} = 2'b00;
    irq_queue_empty = 1'b1;
    miscompares = 0;
    check_count = 0;
    // Fourth row has no top byte lane, so nothing may change
    rows = '{'{32'h1000_0000, 4'hf, 1, 0}, '{32'h0400_0000, 4'hf, 0, 1},
      '{32'h1400_0000, 4'h8, 1, 1}, '{32'h0000_0000, 4'h7, 1, 1},
      '{32'h0000_0000, 4'h8, 0, 0}};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_sts(32'h0000_0000);
    axw(`RGC_IRTA_OFF, 32'h0abc_d000, 4'hf);
    axr(`RGC_FEAT_OFF);
    `CHK("feat", 32'h0000_000f, rd)
    // Fault log pointer load lives outside; enables assume it done
    // Zero in the pointer and flush bits must leave both alone
    foreach (rows[i]) begin
      axw(`RGC_GCMD_OFF, rows[i].d, rows[i].s);
      `CHK("bresp", `RGC_RESP_OKAY, rs)
      @(negedge aclk);
      `CHK("afl", rows[i].afl, adv_fault_log_enable)
      `CHK("qie", rows[i].qi, queued_inval_enable)
      `CHK("flush", 1'b0, write_buffer_flush_req)
      `CHK("ptr", 32'h0, irq_table_ptr)
      chk_sts({3'b0, rows[i].afl, 1'b0, rows[i].qi, 26'h0});
    end
    // Command word answers, but its value is not to be trusted
    axr(`RGC_GCMD_OFF);
    `CHK("rresp", `RGC_RESP_OKAY, rs)
    // Unmapped place: refused both ways, nothing written
    axr(12'h100);
    `CHK("rresp", `RGC_RESP_DECERR, rs)
    axw(12'h100, 32'h1000_0000, 4'hf);
    `CHK("bresp", `RGC_RESP_DECERR, rs)
    `CHK("afl", 1'b0, adv_fault_log_enable)
    // Pointer set before remap is first enabled
    axw(`RGC_GCMD_OFF, 32'h0100_0000, 4'hf);
    `CHK("ptr", 32'h0abc_d000, irq_table_ptr)
    chk_sts(32'h0100_0000);
    axr(`RGC_IRTP_OFF);
    `CHK("irtp", 32'h0abc_d000, rd)
    // Entry cache invalidation would follow here, outside this block
    // Flush stays busy until the root complex answers
    axw(`RGC_GCMD_OFF, 32'h0800_0000, 4'hf);
    @(negedge aclk);
    `CHK("flush", 1'b1, write_buffer_flush_req)
    chk_sts(32'h0900_0000);
    @(posedge aclk);
    write_buffer_flush_done <= 1'b1;
    @(posedge aclk);
    write_buffer_flush_done <= 1'b0;
    @(negedge aclk);
    `CHK("flush", 1'b0, write_buffer_flush_req)
    chk_sts(32'h0100_0000);
    // Remap enable waits for an idle queue and a transaction boundary
    axw(`RGC_GCMD_OFF, 32'h0200_0000, 4'h8);
    @(negedge aclk);
    `CHK("drain", 1'b1, irq_drain_req)
    `CHK("ire", 1'b0, irq_remap_enable)
    chk_sts(32'h0100_0000);
    @(posedge aclk);
    irq_txn_idle <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK("ire", 1'b1, irq_remap_enable)
    `CHK("drain", 1'b0, irq_drain_req)
    chk_sts(32'h0300_0000);
    // Disable held back while requests remain queued
    irq_queue_empty <= 1'b0;
    axw(`RGC_GCMD_OFF, 32'h0000_0000, 4'h8);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK("ire", 1'b1, irq_remap_enable)
    @(posedge aclk);
    irq_queue_empty <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK("ire", 1'b0, irq_remap_enable)
    chk_sts(32'h0100_0000);
    // Fresh pointer before any re-enable; low two lanes only
    axw(`RGC_IRTA_OFF, 32'h1111_2222, 4'h3);
    axr(`RGC_IRTA_OFF);
    `CHK("irta", 32'h0abc_2222, rd)
    // Pointer reloads here while remapping is off, along with fault log and queued invalidation
    axw(`RGC_GCMD_OFF, 32'h1500_0000, 4'h8);
    `CHK("ptr", 32'h0abc_2222, irq_table_ptr)
    chk_sts(32'h1500_0000);
    // Mid-run reset drops every enable and the working pointer
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK("afl", 1'b0, adv_fault_log_enable)
    `CHK("qie", 1'b0, queued_inval_enable)
    `CHK("ptr", 32'h0, irq_table_ptr)
    `CHK("awready", 1'b1, s_axi_awready)
    `CHK("arready", 1'b1, s_axi_arready)
    chk_sts(32'h0000_0000);
    axr(`RGC_IRTA_OFF);
    `CHK("irta", 32'h0, rd)
    wrap_up();
  end
endmodule : remap_global_command_ops_tb_top

`default_nettype wire
